// [common/ptpe_pkg.sv]
package ptpe_pkg;

	// ********************************************************
	// geometry
	// ********************************************************
	localparam int NUM_PORTS = 5;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int OFS_W = 12;
	localparam int NIB_W = ADDR_W - OFS_W;

	// port number carried in the upper address nibble
	localparam logic [NIB_W-1:0] PORT_NUM [NUM_PORTS] = '{
		4'h1, 4'h2, 4'h3, 4'h4, 4'h7
	};

	// ********************************************************
	// per-port register offsets (low twelve address bits)
	// ********************************************************
	localparam logic [OFS_W-1:0] RESP_TIME_OFS = 12'hc12;
	localparam logic [OFS_W-1:0] STATUS_OFS = 12'hc14;
	localparam logic [OFS_W-1:0] ENABLE_OFS = 12'hc16;

	// ********************************************************
	// block-level interrupt registers, upper nibble zero
	// ********************************************************
	localparam logic [NIB_W-1:0] GLB_NIBBLE = 4'h0;
	localparam logic [OFS_W-1:0] GLB_STATUS_OFS = 12'hd00;
	localparam logic [OFS_W-1:0] GLB_CLEAR_OFS = 12'hd02;
	localparam logic [OFS_W-1:0] GLB_ENABLE_OFS = 12'hd04;

	// ********************************************************
	// field layout of status and enable registers
	// ********************************************************
	localparam int SYNC_BIT = 15;
	localparam int REQ_BIT = 14;
	localparam int RESP_BIT = 13;
	localparam int FLAG_HI = 15;
	localparam int FLAG_LO = 13;
	localparam logic [FLAG_LO-1:0] RSVD_ZERO = 13'h0000;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [DATA_W-1:0] TIME_RESET = 16'h0000;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

	// ********************************************************
	// carriers
	// ********************************************************
	typedef struct packed {
		logic sync;
		logic req;
		logic resp;
	} ptpe_flags_t;

	localparam ptpe_flags_t ENABLE_RESET = 3'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ptpe_bus_t;

	typedef struct packed {
		logic sync;
		logic req;
		logic resp;
		logic [DATA_W-1:0] respTime;
	} ptpe_evt_t;

endpackage

// [hw/ptpe_sticky_flag.sv]
module ptpe_sticky_flag
	import ptpe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic setPulse,
	input wire logic clearPulse,
	output logic flag_q
);

	// ********************************************************
	// sticky flag
	// ********************************************************
	// set beats clear so an event in the clear cycle survives
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			flag_q <= FLAG_RESET;
		end else if (setPulse) begin
			flag_q <= 1'b1;
		end else if (clearPulse) begin
			flag_q <= FLAG_RESET;
		end
	end

endmodule

// [hw/ptpe_irq_agg.sv]
module ptpe_irq_agg
	import ptpe_pkg::*;
#(
	parameter int WIDTH = NUM_PORTS
)
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [WIDTH-1:0] evtPulse,
	input wire logic clrWr,
	input wire logic enWr,
	input wire logic [WIDTH-1:0] wrData,
	output logic [WIDTH-1:0] status_q,
	output logic [WIDTH-1:0] enable_q,
	output logic irq_q
);

	// ********************************************************
	// sticky status, write-one clear, set wins
	// ********************************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			status_q <= '0;
		end else begin
			status_q <= evtPulse | (status_q & ~(clrWr ? wrData : '0));
		end
	end

	// enable register of the same layout
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			enable_q <= '0;
		end else if (enWr) begin
			enable_q <= wrData;
		end
	end

	// level output, one cycle behind the registers
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & enable_q);
		end
	end

endmodule

// [hw/ptpe_egress_irq.sv]
// Notes on behaviour
// [RULE_01] Each port shows, read-only, the low word of its response time.
// [RULE_02] Status bit 15 is set by a Sync time and cleared by writing 1.
// [RULE_03] Bit 14 is set by a Pdelay_Req or Delay_Req time, cleared by 1.
// [RULE_04] Bit 13 is set by a Pdelay_Resp time and cleared by writing 1.
// [RULE_05] The port summary status is the OR of the port's three flags.
// [RULE_06] Enable bit 15 permits the Sync interrupt and resets to 0.
// [RULE_07] Bit 14 permits the Pdelay_Req and Delay_Req interrupt, reset 0.
// [RULE_08] Bit 13 permits the Pdelay_Resp interrupt, reset 0.
// [RULE_09] The port summary enable is the OR of the port's three enables.
// [RULE_10] Bits 12 to 0 of status and enable read as zero and ignore writes.
// [RULE_11] Flags stay until cleared; a port irq needs an enabled set flag.
//
// Local design decision: strobed register access.
module ptpe_egress_irq
	import ptpe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire ptpe_bus_t bus,
	input wire ptpe_evt_t [NUM_PORTS-1:0] portEvt,
	output logic [DATA_W-1:0] readData_q,
	output logic [NUM_PORTS-1:0] portTsStatus_q,
	output logic [NUM_PORTS-1:0] portTsEnable_q,
	output logic [NUM_PORTS-1:0] portTsIrq_q,
	output logic irq_q
);

	// ********************************************************
	// address decode
	// ********************************************************
	logic [NIB_W-1:0] addrNib;
	logic [OFS_W-1:0] regOfs;
	logic [NUM_PORTS-1:0] portHit;
	logic globalHit;

	assign addrNib = bus.addr[ADDR_W-1:OFS_W];
	assign regOfs = bus.addr[OFS_W-1:0];
	assign globalHit = (addrNib == GLB_NIBBLE);

	// one hit line per port, ports are sparse in the map
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			portHit[p] = (addrNib == PORT_NUM[p]);
		end
	end

	// ********************************************************
	// write strobes
	// ********************************************************
	logic [NUM_PORTS-1:0] statusWr;
	logic [NUM_PORTS-1:0] enableWr;
	logic glbClrWr;
	logic glbEnWr;

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			statusWr[p] = bus.wr & portHit[p] & (regOfs == STATUS_OFS);
			enableWr[p] = bus.wr & portHit[p] & (regOfs == ENABLE_OFS);
		end
	end

	assign glbClrWr = bus.wr & globalHit & (regOfs == GLB_CLEAR_OFS);
	assign glbEnWr = bus.wr & globalHit & (regOfs == GLB_ENABLE_OFS);

	// write-one clear pulses per flag, upper three data bits only
	logic [NUM_PORTS-1:0] clrSync;
	logic [NUM_PORTS-1:0] clrReq;
	logic [NUM_PORTS-1:0] clrResp;

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			clrSync[p] = statusWr[p] & bus.wdata[SYNC_BIT];
			clrReq[p] = statusWr[p] & bus.wdata[REQ_BIT];
			clrResp[p] = statusWr[p] & bus.wdata[RESP_BIT];
		end
	end

	// ********************************************************
	// sticky status flags
	// ********************************************************
	logic [NUM_PORTS-1:0] flagSync;
	logic [NUM_PORTS-1:0] flagReq;
	logic [NUM_PORTS-1:0] flagResp;

	for (genvar g = 0; g < NUM_PORTS; g++) begin : gPort
		// [RULE_02] sync time flag
		ptpe_sticky_flag uSync (
			.clk_sys(clk_sys),
			.srst(srst),
			.setPulse(portEvt[g].sync),
			.clearPulse(clrSync[g]),
			.flag_q(flagSync[g])
		);
		// [RULE_03] request time flag
		ptpe_sticky_flag uReq (
			.clk_sys(clk_sys),
			.srst(srst),
			.setPulse(portEvt[g].req),
			.clearPulse(clrReq[g]),
			.flag_q(flagReq[g])
		);
		// [RULE_04] response time flag
		ptpe_sticky_flag uResp (
			.clk_sys(clk_sys),
			.srst(srst),
			.setPulse(portEvt[g].resp),
			.clearPulse(clrResp[g]),
			.flag_q(flagResp[g])
		);
	end

	// regroup the flags into the register layout
	ptpe_flags_t flags [NUM_PORTS];

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			flags[p].sync = flagSync[p];
			flags[p].req = flagReq[p];
			flags[p].resp = flagResp[p];
		end
	end

	// ********************************************************
	// enable registers
	// ********************************************************
	ptpe_flags_t enable_q [NUM_PORTS];

	// [RULE_06] [RULE_07] [RULE_08] enable bits, cleared at reset
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				enable_q[p] <= ENABLE_RESET;
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				// [RULE_10] low bits are never stored
				if (enableWr[p]) begin
					enable_q[p] <= bus.wdata[FLAG_HI:FLAG_LO];
				end
			end
		end
	end

	// ********************************************************
	// response egress time capture
	// ********************************************************
	logic [DATA_W-1:0] respTime_q [NUM_PORTS];

	// [RULE_01] latest response time wins, flag untouched
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				respTime_q[p] <= TIME_RESET;
			end
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (portEvt[p].resp) begin
					respTime_q[p] <= portEvt[p].respTime;
				end
			end
		end
	end

	// ********************************************************
	// per-port summaries
	// ********************************************************
	logic [NUM_PORTS-1:0] portIrqNow;

	// [RULE_11] needs a set flag whose own enable is on
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			portIrqNow[p] = |(flags[p] & enable_q[p]);
		end
	end

	// registered so every output comes off a flop
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			portTsStatus_q <= '0;
			portTsEnable_q <= '0;
			portTsIrq_q <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				// [RULE_05] or of status flags
				portTsStatus_q[p] <= |flags[p];
				// [RULE_09] or of enable bits
				portTsEnable_q[p] <= |enable_q[p];
				portTsIrq_q[p] <= portIrqNow[p];
			end
		end
	end

	// ********************************************************
	// block interrupt
	// ********************************************************
	// a port raises an event on the rise of its masked level
	logic [NUM_PORTS-1:0] portIrqRise;
	logic [NUM_PORTS-1:0] glbStatus;
	logic [NUM_PORTS-1:0] glbEnable;

	assign portIrqRise = portIrqNow & ~portTsIrq_q;

	ptpe_irq_agg #(
		.WIDTH(NUM_PORTS)
	) uAgg (
		.clk_sys(clk_sys),
		.srst(srst),
		.evtPulse(portIrqRise),
		.clrWr(glbClrWr),
		.enWr(glbEnWr),
		.wrData(bus.wdata[NUM_PORTS-1:0]),
		.status_q(glbStatus),
		.enable_q(glbEnable),
		.irq_q(irq_q)
	);

	// ********************************************************
	// read path
	// ********************************************************
	logic [DATA_W-1:0] readNext;

	// unmapped and write-only addresses answer zero
	always_comb begin
		readNext = READ_IDLE;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (portHit[p]) begin
				unique case (regOfs)
					RESP_TIME_OFS: begin
						readNext = respTime_q[p];
					end
					// [RULE_10] reserved bits zero
					STATUS_OFS: begin
						readNext = {flags[p], RSVD_ZERO};
					end
					ENABLE_OFS: begin
						readNext = {enable_q[p], RSVD_ZERO};
					end
					default: begin
						readNext = READ_IDLE;
					end
				endcase
			end
		end
		if (globalHit) begin
			if (regOfs == GLB_STATUS_OFS) begin
				readNext = {{(DATA_W-NUM_PORTS){1'b0}}, glbStatus};
			end else if (regOfs == GLB_ENABLE_OFS) begin
				readNext = {{(DATA_W-NUM_PORTS){1'b0}}, glbEnable};
			end
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			readData_q <= READ_IDLE;
		end else if (bus.rd) begin
			readData_q <= readNext;
		end else begin
			readData_q <= READ_IDLE;
		end
	end

endmodule

// [bench/ptpe_egress_irq_assertions.sv]
module ptpe_egress_irq_assertions
	import ptpe_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire ptpe_bus_t bus,
	input wire ptpe_evt_t [NUM_PORTS-1:0] portEvt,
	input wire logic [DATA_W-1:0] readData_q,
	input wire logic [NUM_PORTS-1:0] portTsStatus_q,
	input wire logic [NUM_PORTS-1:0] portTsEnable_q,
	input wire logic [NUM_PORTS-1:0] portTsIrq_q,
	input wire logic irq_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic clr0;
	logic enW0;
	logic rdReg;
	logic [DATA_W-1:0] lastTime_q;
	// port 1 stands for all ports, the logic is shared
	assign clr0 = bus.wr && bus.addr == 16'h1c14 && |bus.wdata[15:13];
	assign enW0 = |bus.wdata[15:13];
	assign rdReg = bus.rd && bus.addr[11:0] inside {12'hc14, 12'hc16};

	// reference copy of the latest response time on port 1
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lastTime_q <= TIME_RESET;
		end else if (portEvt[0].resp) begin
			lastTime_q <= portEvt[0].respTime;
		end
	end

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// resp event followed by a quiet cycle
	sequence respEvt;
		portEvt[0].resp ##1 !portEvt[0].resp;
	endsequence
	// read strobe on the response time register
	sequence rdTime;
		bus.rd && bus.addr == 16'h1c12;
	endsequence
	a_read_idle: assert property (!$past(bus.rd) |-> !readData_q)
		else $error("read data not idle");
	a_resp_time: assert property (rdTime |=>
		readData_q == $past(lastTime_q)) else $error("bad time");
	a_resp_sets: assert property (respEvt |=> portTsStatus_q[0])
		else $error("resp flag lost");
	a_sync_sets: assert property (
		portEvt[0].sync |-> ##2 portTsStatus_q[0])
		else $error("sync flag lost");
	a_flag_sticky: assert property (
		portTsStatus_q[0] && !$past(clr0) |=> portTsStatus_q[0])
		else $error("flag dropped");
	a_enable_or: assert property (
		bus.wr && bus.addr == 16'h1c16 |-> ##2 portTsEnable_q[0] == $past(enW0, 2))
		else $error("enable summary wrong");
	a_irq_masked: assert property (
		portTsIrq_q == (portTsIrq_q & portTsStatus_q & portTsEnable_q))
		else $error("irq without flag and enable");
	a_rsvd_zero: assert property (
		$past(rdReg) |-> readData_q[12:0] == 13'h0000)
		else $error("reserved bits set");
	a_glb_mask: assert property (
		bus.wr && bus.addr == 16'h0d04 && bus.wdata[4:0] == 5'h00 |-> ##2 !irq_q)
		else $error("masked irq high");
endmodule

bind ptpe_egress_irq ptpe_egress_irq_assertions ptpe_egress_irq_assertions_inst (
	.clk_sys, .srst, .bus, .portEvt, .readData_q, .portTsStatus_q,
	.portTsEnable_q, .portTsIrq_q, .irq_q
);

// [bench/ptp_egress_timestamp_irq_test.sv]
module ptp_egress_timestamp_irq_test
	import ptpe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	ptpe_bus_t bus = '0;
	ptpe_evt_t [NUM_PORTS-1:0] portEvt = '0;
	logic [DATA_W-1:0] readData_q;
	logic [NUM_PORTS-1:0] portTsStatus_q;
	logic [NUM_PORTS-1:0] portTsEnable_q;
	logic [NUM_PORTS-1:0] portTsIrq_q;
	logic irq_q;
	logic [DATA_W-1:0] expQ [$];
	logic rdPend = 1'b0;
	int errCount = 0;
	int checksDone = 0;
	int cycles = 0;

	ptpe_egress_irq ptpe_egress_irq_inst (
		.clk_sys, .srst, .bus, .portEvt, .readData_q, .portTsStatus_q,
		.portTsEnable_q, .portTsIrq_q, .irq_q
	);

	// free-running system clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		checksDone++;
		if (seen !== exp) begin
			errCount++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finalReport();
		if (expQ.size() != 0)
			errCount++;
		$display("mismatches %0d comparisons %0d", errCount, checksDone);
		if (errCount == 0 && checksDone > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// bus cycles: strobe one cycle, one idle edge before the next
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		expQ.push_back(e);
		@(posedge clk_sys);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
	endtask

	// one-cycle egress event of kind k on port index p
	task automatic evt(input int p, input int k, input logic [DATA_W-1:0] t);
		@(posedge clk_sys);
		portEvt[p].sync <= (k == 0);
		portEvt[p].req <= (k == 1);
		portEvt[p].resp <= (k == 2);
		portEvt[p].respTime <= t;
		@(posedge clk_sys);
		portEvt[p] <= '0;
	endtask

	// summary outputs lag, so let them land before looking
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (rdPend)
			check(readData_q, expQ.pop_front());
		rdPend <= bus.rd;
		// hang guard, far above the few hundred cycles the run needs
		if (cycles == 5000) begin
			errCount++;
			finalReport();
		end
	end

	initial begin
		logic [DATA_W-1:0] sa;
		logic [DATA_W-1:0] ea;
		logic [DATA_W-1:0] ta;
		logic [DATA_W-1:0] r;
		logic [DATA_W-1:0] t;
		logic [DATA_W-1:0] acc;
		logic [2:0] e;
		logic [NUM_PORTS-1:0] g;
		void'($urandom(69));
		g = '0;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		wr(16'h0d04, 16'h001f);
		rd(16'h0d04, 16'h001f);
		rd(16'h0c14, 16'h0000);
		rd(16'h1c18, 16'h0000);
		for (int p = 0; p < NUM_PORTS; p++) begin
			ta = {PORT_NUM[p], RESP_TIME_OFS};
			sa = {PORT_NUM[p], STATUS_OFS};
			ea = {PORT_NUM[p], ENABLE_OFS};
			rd(ta, 16'h0000);
			rd(sa, 16'h0000);
			rd(ea, 16'h0000);
			r = 16'($urandom);
			if (p == 0)
				r[13] = 1'b1; // at least one port must raise the block irq
			e = r[15:13];
			wr(ea, r);
			rd(ea, {e, 13'h0000});
			settle();
			check(16'(portTsEnable_q[p]), 16'(|e));
			acc = 16'h0000;
			t = 16'($urandom);
			for (int k = 0; k < 3; k++) begin
				evt(p, k, t);
				acc = acc | (16'h8000 >> k);
				rd(sa, acc);
			end
			// time is read-only and only a resp event moves it
			wr(ta, ~t);
			evt(p, 0, ~t);
			rd(ta, t);
			wr(sa, 16'h1fff);
			rd(sa, 16'he000);
			settle();
			check(16'(portTsStatus_q[p]), 16'h0001);
			check(16'(portTsIrq_q[p]), 16'(|e));
			g[p] = |e;
			for (int k = 0; k < 3; k++) begin
				wr(sa, 16'h8000 >> k);
				acc = (16'he000 >> (k + 1)) & 16'he000;
				rd(sa, acc);
			end
			settle();
			check(16'(portTsStatus_q[p]), 16'h0000);
			check(16'(portTsIrq_q[p]), 16'h0000);
		end
		rd(16'h0d00, {11'h000, g});
		check(16'(irq_q), 16'h0001);
		wr(16'h0d04, 16'h0000);
		settle();
		check(16'(irq_q), 16'h0000);
		wr(16'h0d04, 16'h001f);
		wr(16'h0d02, 16'h001f);
		rd(16'h0d00, 16'h0000);
		rd(16'h0d02, 16'h0000);
		settle();
		check(16'(irq_q), 16'h0000);
		finalReport();
	end
endmodule
